// [rtl/sram_port_regs.vh]
// widths and depths of the synchronous sram input port
`ifndef SRAM_PORT_REGS_VH
`define SRAM_PORT_REGS_VH
`define SIP_DATA_W 36
`define SIP_NARROW_W 18
`define SIP_LANES 4
`define SIP_LANE_W 9
`define SIP_ADDR_W 22
`define SIP_FIFO_DEPTH 16
`define SIP_FIFO_AW 4
`define SIP_MEM_AW 4
`define SIP_WIDE 1
`endif

// [rtl/sync_sram_input_port.v]
// command, address and byte-write input port of a two-port burst-of-two sram
`timescale 1ns/1ns
`include "sram_port_regs.vh"

// ==========================================================
// write command fifo
module sip_fifo #(
  parameter W = 8,
  parameter DEPTH = `SIP_FIFO_DEPTH,
  parameter AW = `SIP_FIFO_AW
) (
  input wire mclk,
  input wire srst,
  input wire [W-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [W-1:0] outData,
  output wire outValid,
  input wire outReady
);
  localparam [31:0] DEPTH_WORD = DEPTH;
  localparam [AW:0] FULL = DEPTH_WORD[AW:0];
  reg [W-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wPtr;
  reg [AW-1:0] rPtr;
  reg [AW:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = (count != FULL);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = store[rPtr];
  always @(posedge mclk) begin
    if (push) begin
      store[wPtr] <= inData;
    end
  end
  always @(posedge mclk) begin
    if (srst) begin
      wPtr <= {AW{1'b0}};
      rPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wPtr <= wPtr + 1'b1;
      end
      if (pop) begin
        rPtr <= rPtr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule

// ==========================================================
// input port top
// Behaviour
// RULE1 - read address captured on true clock rise
// RULE2 - write address captured on complement clock rise
// RULE3 - deselected: address ignored, no access
// RULE4 - read select low starts read
// RULE5 - write select low starts write
// RULE6 - only enabled byte lanes are stored
// RULE7 - lane enables sampled with their data beat
// RULE8 - two beats, each with own enables
// RULE9 - control on true clock, data both
// RULE10 - narrow uses lower eighteen data bits
// RULE11 - both selects high: no new access
// RULE12 - read and write accepted together
module sync_sram_input_port #(
  parameter DW = `SIP_DATA_W,
  parameter LANES = `SIP_LANES,
  parameter AW = `SIP_ADDR_W,
  parameter MEM_AW = `SIP_MEM_AW,
  parameter WIDE = `SIP_WIDE
) (
  input wire mclk,
  input wire srst,
  input wire kClk,
  input wire kClkN,
  input wire readSelN,
  input wire writeSelN,
  input wire [AW-1:0] sharedAddrBus,
  input wire [LANES-1:0] byteLaneWriteN,
  input wire [DW-1:0] writeData,
  output reg rdValid,
  output reg [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData0,
  output reg [DW-1:0] rdData1,
  output reg wrBusy,
  output reg wrDropped
);
  localparam FW = AW + 2 * (DW + LANES);

  // ==========================================================
  // lane mask, narrow organisation drops the upper lanes
  function [DW-1:0] laneMask;
    input [LANES-1:0] beN;
    integer i;
    begin
      laneMask = {DW{1'b0}};
      for (i = 0; i < LANES; i = i + 1) begin
        if (!beN[i] && (WIDE != 0 || i * `SIP_LANE_W < `SIP_NARROW_W)) begin // see RULE10
          laneMask[i*`SIP_LANE_W +: `SIP_LANE_W] = {`SIP_LANE_W{1'b1}}; // see RULE6
        end
      end
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg [1:0] kSync;
  reg [1:0] knSync;
  reg [1:0] rSync;
  reg [1:0] wSync;
  reg [AW-1:0] addrS1;
  reg [AW-1:0] addrS2;
  reg [DW-1:0] dataS1;
  reg [DW-1:0] dataS2;
  reg [LANES-1:0] beS1;
  reg [LANES-1:0] beS2;
  reg kPrev;
  reg knPrev;
  always @(posedge mclk) begin
    if (srst) begin
      kSync <= 2'b00;
      knSync <= 2'b00;
      rSync <= 2'b11;
      wSync <= 2'b11;
      kPrev <= 1'b0;
      knPrev <= 1'b0;
    end else begin
      kSync <= {kSync[0], kClk};
      knSync <= {knSync[0], kClkN};
      rSync <= {rSync[0], readSelN};
      wSync <= {wSync[0], writeSelN};
      kPrev <= kSync[1];
      knPrev <= knSync[1];
    end
  end
  always @(posedge mclk) begin
    addrS1 <= sharedAddrBus;
    addrS2 <= addrS1;
    dataS1 <= writeData;
    dataS2 <= dataS1;
    beS1 <= byteLaneWriteN;
    beS2 <= beS1;
  end
  wire kRise = kSync[1] && !kPrev;
  wire knRise = knSync[1] && !knPrev;

  // ==========================================================
  // command capture
  reg wrPending;
  reg [DW-1:0] beat0Data;
  reg [LANES-1:0] beat0BeN;
  wire fifoInReady;
  wire wrPush = knRise && wrPending;
  wire [FW-1:0] fifoIn = {addrS2, beS2, dataS2, beat0BeN, beat0Data}; // see RULE2
  wire [FW-1:0] fifoOut;
  wire fifoOutValid;
  reg beatSel;
  reg [DW-1:0] store [0:(2 << MEM_AW)-1];
  always @(posedge mclk) begin
    if (srst) begin
      wrPending <= 1'b0;
      beat0Data <= {DW{1'b0}};
      beat0BeN <= {LANES{1'b1}};
      rdValid <= 1'b0;
      rdAddr <= {AW{1'b0}};
      rdData0 <= {DW{1'b0}};
      rdData1 <= {DW{1'b0}};
      wrBusy <= 1'b0;
      wrDropped <= 1'b0;
    end else begin
      rdValid <= 1'b0;
      wrBusy <= !fifoInReady;
      if (kRise && !rSync[1]) begin // see RULE4, RULE1, RULE12, RULE3
        rdValid <= 1'b1;
        rdAddr <= addrS2;
        // unused upper lanes of the narrow organisation read as zero
        rdData0 <= store[{addrS2[MEM_AW-1:0], 1'b0}] & laneMask({LANES{1'b0}}); // see RULE10
        rdData1 <= store[{addrS2[MEM_AW-1:0], 1'b1}] & laneMask({LANES{1'b0}}); // see RULE10
      end
      if (kRise) begin
        wrPending <= !wSync[1]; // see RULE5, RULE9, RULE11
        beat0Data <= dataS2; // see RULE8
        beat0BeN <= beS2; // see RULE7
      end else if (wrPush) begin
        wrPending <= 1'b0;
        if (!fifoInReady) begin
          wrDropped <= 1'b1;
        end
      end
    end
  end

  sip_fifo #(
    .W(FW),
    .DEPTH(`SIP_FIFO_DEPTH),
    .AW(`SIP_FIFO_AW)
  ) writeQueue (
    .mclk(mclk),
    .srst(srst),
    .inData(fifoIn),
    .inValid(wrPush),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(beatSel)
  );

  // ==========================================================
  // array write, one beat per cycle
  wire [DW-1:0] drainData = beatSel ? fifoOut[2*DW+LANES-1 -: DW] : fifoOut[DW-1:0];
  wire [LANES-1:0] drainBeN = beatSel ? fifoOut[2*DW+2*LANES-1 -: LANES]
                                      : fifoOut[DW+LANES-1 -: LANES];
  wire [MEM_AW-1:0] drainAddr = fifoOut[2*DW+2*LANES +: MEM_AW];
  wire [DW-1:0] drainMask = laneMask(drainBeN);
  wire [MEM_AW:0] drainIdx = {drainAddr, beatSel};
  always @(posedge mclk) begin
    if (srst) begin
      beatSel <= 1'b0;
    end else if (fifoOutValid) begin
      beatSel <= !beatSel;
    end
  end
  always @(posedge mclk) begin
    if (fifoOutValid) begin
      store[drainIdx] <= (store[drainIdx] & ~drainMask) | (drainData & drainMask); // see RULE6
    end
  end
endmodule

// [tb/sip_chk.sv]
// assertions on the read side of the sram input port
`timescale 1ns/1ns
module sip_chk (
  input wire mclk,
  input wire srst,
  input wire kClk,
  input wire readSelN,
  input wire [21:0] sharedAddrBus,
  input wire rdValid,
  input wire [21:0] rdAddr,
  input wire [35:0] rdData0
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  sequence readAsked;
    $rose(kClk) && !readSelN;
  endsequence
  sequence readSkipped;
    $rose(kClk) && readSelN;
  endsequence
  rd_take_a: assert property (readAsked |-> ##[2:6] rdValid)
    else $error("read lost");
  rd_cause_a: assert property (rdValid |-> !$past(readSelN, 3))
    else $error("read unasked");
  rd_addr_a: assert property (rdValid |-> rdAddr == $past(sharedAddrBus, 2))
    else $error("read address");
  rd_once_a: assert property (rdValid |=> !rdValid)
    else $error("read twice");
  rd_skip_a: assert property (readSkipped |=> (!rdValid) [*6])
    else $error("deselected read");
  addr_hold_a: assert property (!rdValid |-> $stable(rdAddr))
    else $error("address moved");
  data_hold_a: assert property (!rdValid |-> $stable(rdData0))
    else $error("data moved");
  idle_quiet_a: assert property (readSelN [*6] |=> !rdValid)
    else $error("idle read");
endmodule
bind sync_sram_input_port sip_chk sip_chk_inst (.*);

// [tb/sip_ctl_model.sv]
// controller model: link clocks, selects, address, data, lane enables
`timescale 1ns/1ns
module sip_ctl_model (
  input wire mclk,
  output logic kClk = 0,
  output logic kClkN = 0,
  output logic readSelN = 1,
  output logic writeSelN = 1,
  output logic [21:0] sharedAddrBus = 0,
  output logic [3:0] byteLaneWriteN = 0,
  output logic [35:0] writeData = 0
);
  // one link period of eight mclk; clocks stand still between calls
  task burst(input logic r, w, input logic [21:0] ra, wa, input logic [71:0] d,
    input logic [7:0] b);
    @(posedge mclk);
    {kClk, kClkN, readSelN, writeSelN} <= {2'b10, !r, !w};
    {sharedAddrBus, writeData, byteLaneWriteN} <= {ra, d[35:0], b[3:0]};
    repeat (4) @(posedge mclk);
    {kClk, kClkN} <= 2'b01;
    {sharedAddrBus, writeData, byteLaneWriteN} <= {wa, d[71:36], b[7:4]};
    repeat (3) @(posedge mclk);
    {kClkN, readSelN, writeSelN} <= 3'b011;
    {sharedAddrBus, writeData, byteLaneWriteN} <= ~{wa, d[71:36], b[7:4]};
  endtask
endmodule

// [tb/sync_sram_input_port_test.sv]
// self-checking bench of the sram input port
`timescale 1ns/1ns
module sync_sram_input_port_test;
  logic mclk = 0, srst = 1, r, w;
  wire kClk, kClkN, readSelN, writeSelN, rdValid, wrBusy, wrDropped;
  wire [21:0] sharedAddrBus, rdAddr;
  wire [3:0] byteLaneWriteN;
  wire [35:0] writeData, rdData0, rdData1;
  wire narrowValid, narrowBusy, narrowDropped;
  wire [21:0] narrowAddr;
  wire [35:0] narrowData0, narrowData1;
  logic [21:0] ra, wa;
  logic [71:0] d, mem [16];
  logic [7:0] b;
  logic [31:0] x, seed = 32'h0001_19c9;
  logic [93:0] expQ [$], expN [$];
  int fail_count = 0, total_checks = 0;
  always #10 mclk = ~mclk;
  sip_ctl_model sip_ctl_model_inst (.*);
  sync_sram_input_port sync_sram_input_port_inst (.*);
  // narrow organisation on the same controller: only lanes 0 and 1 of each beat
  sync_sram_input_port #(.WIDE(0)) sync_sram_input_port_narrow_inst (
    .mclk(mclk),
    .srst(srst),
    .kClk(kClk),
    .kClkN(kClkN),
    .readSelN(readSelN),
    .writeSelN(writeSelN),
    .sharedAddrBus(sharedAddrBus),
    .byteLaneWriteN(byteLaneWriteN),
    .writeData(writeData),
    .rdValid(narrowValid),
    .rdAddr(narrowAddr),
    .rdData0(narrowData0),
    .rdData1(narrowData1),
    .wrBusy(narrowBusy),
    .wrDropped(narrowDropped)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // merge the enabled 9-bit lanes of d into old; enables active low
  function automatic logic [71:0] lanes(input logic [71:0] old, d, input logic [7:0] b);
    lanes = old;
    for (int j = 0; j < 8; j++) begin
      if (!b[j]) begin
        lanes[9*j +: 9] = d[9*j +: 9];
      end
    end
  endfunction
  task chk(string s, logic [93:0] e, g);
    total_checks++;
    if (e !== g) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task complete_run();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rdValid === 1'b1) begin
      chk("read", expQ.size() ? expQ.pop_front() : '1, {rdAddr, rdData1, rdData0});
    end
    if (narrowValid === 1'b1) begin
      chk("narrow", expN.size() ? expN.pop_front() : '1,
        {narrowAddr, narrowData1, narrowData0});
    end
    if (wrBusy !== 1'b0 || narrowBusy !== 1'b0) begin
      chk("busy", 0, 94'({wrBusy, narrowBusy}));
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 0;
    repeat (3) @(posedge mclk);
    // reads take the parity of the current write, never of the one just before
    for (int i = 0; i < 60; i++) begin
      x = rnd();
      {r, w, b} = {i > 15 && x[0], i < 16 || x[1], i < 16 ? 8'h00 : i == 16 ? 8'hff : x[9:2]};
      ra = 22'({rnd(), i[0]});
      wa = 22'(i < 16 ? i : {rnd(), i[0]});
      d = 72'({rnd(), rnd(), rnd()});
      if (r) begin
        expQ.push_back({ra, mem[ra[3:0]]});
        // narrow keeps lanes 0 and 1 of each beat, the rest reads as zero
        expN.push_back({ra, lanes(72'h0, mem[ra[3:0]], 8'hcc)});
      end
      sip_ctl_model_inst.burst(r, w, ra, wa, d, b);
      if (w) begin
        mem[wa[3:0]] = lanes(mem[wa[3:0]], d, b);
      end
    end
    repeat (16) @(posedge mclk);
    chk("leftover", 0, 94'(expQ.size() + expN.size()));
    chk("dropped", 0, 94'({wrDropped, narrowDropped}));
    complete_run();
  end
endmodule
